// ---- retdec_cfg.svh ----
// Constants for the return and miscellaneous opcode decoder.
// Assumes it is included by the package and the design modules only.
`ifndef RETDEC_CFG_SVH
`define RETDEC_CFG_SVH
`define OPC_IDLE_MASK      14'h3F9F
`define OPC_IDLE_VAL       14'h0000
`define OPC_IRQ_RET        14'h0009
`define OPC_LOAD_CFG       14'h0062
`define OPC_RETLIT_MASK    14'h3C00
`define OPC_RETLIT_VAL     14'h3400
`define GATE_BIT_POS       7
`define PC_RESET           11'h000
`define W_RESET            8'h00
`define CFG_RESET          8'hFF
`define IRQ_CTRL_RESET     8'h00
`define FLAGS_RESET        8'h00
`define RDATA_RESET        8'h00
`define CFG_FILE_ADDR      7'h01
`define IRQ_CTRL_FILE_ADDR 7'h0B
`endif

// ---- retdec_pkg.sv ----
// Types shared by the decoder modules.
// Assumes the constant header sits in the same folder.
`include "retdec_cfg.svh"
package retdec_pkg;
   typedef enum logic [2:0] {
      OP_OTHER_type  = 3'h0,
      OP_IDLE_type   = 3'h1,
      OP_IRQRET_type = 3'h3,
      OP_LDCFG_type  = 3'h2,
      OP_RETLIT_type = 3'h6
   } op_kind_type;
   typedef enum logic [1:0] {
      ST_FETCH_type = 2'h0,
      ST_FLUSH_type = 2'h1
   } exec_state_type;
endpackage : retdec_pkg

// ---- op_kind_if.sv ----
// Carries the decoded instruction between the decoder and the core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface op_kind_if;
   retdec_pkg::op_kind_type kind;
   logic [7:0]              literal;
   modport dec (output kind, output literal);
   modport core (input kind, input literal);
endinterface : op_kind_if

// ---- op_classifier.sv ----
// Pure decoder that sorts one instruction word into an operation kind.
// Assumes the word is stable for the whole cycle it is presented.
`timescale 1ns/1ps
`include "retdec_cfg.svh"
module op_classifier (
   // Instruction word
   input  wire logic [13:0] i_word,
   // Decoded result
   op_kind_if.dec           dec
);
   import retdec_pkg::*;

   function automatic op_kind_type classify(input logic [13:0] w);
      if ((w & `OPC_IDLE_MASK) == `OPC_IDLE_VAL) begin
         return OP_IDLE_type;
      end else if (w == `OPC_IRQ_RET) begin
         return OP_IRQRET_type;
      end else if (w == `OPC_LOAD_CFG) begin
         return OP_LDCFG_type;
      end else if ((w & `OPC_RETLIT_MASK) == `OPC_RETLIT_VAL) begin
         return OP_RETLIT_type;
      end else begin
         return OP_OTHER_type;
      end
   endfunction : classify

   assign dec.kind    = classify(i_word);
   assign dec.literal = i_word[7:0];
endmodule : op_classifier

// ---- return_and_misc_op_decode.sv ----
// Execute stage for idle, interrupt return, config load and literal return.
// Assumes words come from program memory on the same clock and the stack
// pop is serviced combinationally by the stack outside.
// The word shown during the flush cycle is dropped while the counter steps.
`timescale 1ns/1ps
`include "retdec_cfg.svh"
module return_and_misc_op_decode (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // Program memory fetch
   input  wire logic [13:0] i_instr_word,
   output logic [10:0]      o_program_counter,
   // Return stack
   input  wire logic [10:0] i_stack_top_entry,
   output logic             o_stack_pop,
   // File register access
   input  wire logic [6:0]  i_file_addr,
   input  wire logic        i_file_wr,
   input  wire logic [7:0]  i_file_wdata,
   output logic [7:0]       o_file_rdata,
   // Core state
   output logic [7:0]       o_w_reg,
   output logic [7:0]       o_prescale_cfg,
   output logic             o_global_irq_gate,
   output logic [7:0]       o_status_flags,
   output logic             o_flush
);
   import retdec_pkg::*;

   op_kind_if         opk ();
   exec_state_type    state_ff;
   logic [10:0]       pc_ff;
   logic [7:0]        w_ff;
   logic [7:0]        cfg_ff;
   logic [7:0]        irq_ctrl_ff;
   logic              pop_ff;
   logic [7:0]        rdata_ff;
   logic              active;
   logic              is_ret;
   logic              flush_ff;
   logic [7:0]        flags_ff;

   op_classifier u_cls (
      .i_word (i_instr_word),
      .dec    (opk.dec)
   );

   // The word fetched behind a taken return is discarded in the flush cycle.
   assign active = (state_ff == ST_FETCH_type);
   assign is_ret = active && (opk.kind == OP_IRQRET_type ||
                              opk.kind == OP_RETLIT_type);

   // Two states suffice: every taken return costs exactly one dead cycle.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= ST_FETCH_type;
      end else if (is_ret) begin
         state_ff <= ST_FLUSH_type;
      end else begin
         state_ff <= ST_FETCH_type;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_ff <= `PC_RESET;
      end else if (is_ret) begin
         pc_ff <= i_stack_top_entry;
      end else begin
         pc_ff <= pc_ff + 11'h001;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pop_ff <= 1'b0;
      end else begin
         pop_ff <= is_ret;
      end
   end

   // A registered copy keeps the flush output glitch free for the fetch side.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flush_ff <= 1'h0;
      end else begin
         flush_ff <= is_ret;
      end
   end

   // No operation here writes a flag, so the register only ever holds.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_ff <= `FLAGS_RESET;
      end else begin
         flags_ff <= flags_ff;
      end
   end

   // Only the literal return writes the accumulator in this block.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_ff <= `W_RESET;
      end else if (active && opk.kind == OP_RETLIT_type) begin
         w_ff <= opk.literal;
      end
   end

   // Load instruction is kept only for old code; it wins over a same-cycle file write.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_ff <= `CFG_RESET;
      end else if (active && opk.kind == OP_LDCFG_type) begin
         cfg_ff <= w_ff;
      end else if (i_file_wr && i_file_addr == `CFG_FILE_ADDR) begin
         cfg_ff <= i_file_wdata;
      end
   end

   // The gate set by the return wins over a same-cycle software write.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_ctrl_ff <= `IRQ_CTRL_RESET;
      end else begin
         if (i_file_wr && i_file_addr == `IRQ_CTRL_FILE_ADDR) begin
            irq_ctrl_ff <= i_file_wdata;
         end
         if (active && opk.kind == OP_IRQRET_type) begin
            irq_ctrl_ff[`GATE_BIT_POS] <= 1'b1;
         end
      end
   end

   // Read data lags the address by one cycle, unlike the fetched word, which follows the counter in the same cycle.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_ff <= `RDATA_RESET;
      end else if (i_file_addr == `CFG_FILE_ADDR) begin
         rdata_ff <= cfg_ff;
      end else if (i_file_addr == `IRQ_CTRL_FILE_ADDR) begin
         rdata_ff <= irq_ctrl_ff;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign o_program_counter = pc_ff;
   assign o_stack_pop       = pop_ff;
   assign o_file_rdata      = rdata_ff;
   assign o_w_reg           = w_ff;
   assign o_prescale_cfg    = cfg_ff;
   assign o_global_irq_gate = irq_ctrl_ff[`GATE_BIT_POS];
   assign o_status_flags    = flags_ff;
   assign o_flush           = flush_ff;

   // Checks sit beside the logic; reset masks every attempt in flight.
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   AST_IRQRET_PC: assert property (
      is_ret |=> pc_ff == $past(i_stack_top_entry))
      else $error("Return did not load stack top.");
   AST_IRQRET_GATE: assert property (
      active && opk.kind == OP_IRQRET_type |=> o_global_irq_gate)
      else $error("Gate not set by interrupt return.");
   AST_IRQRET_TWO: assert property (
      active && opk.kind == OP_IRQRET_type |=> o_flush ##1 !o_flush)
      else $error("Interrupt return not two cycles.");
   AST_LDCFG: assert property (
      active && opk.kind == OP_LDCFG_type |=> cfg_ff == $past(w_ff))
      else $error("Config not loaded from accumulator.");
   AST_FILE_CFG: assert property (
      i_file_wr && i_file_addr == `CFG_FILE_ADDR
      && !(active && opk.kind == OP_LDCFG_type)
      |=> cfg_ff == $past(i_file_wdata))
      else $error("File write to config lost.");
   AST_RETLIT_W: assert property (
      active && opk.kind == OP_RETLIT_type
      |=> w_ff == $past(i_instr_word[7:0]))
      else $error("Literal not loaded.");
   AST_RETLIT_POP: assert property (
      active && opk.kind == OP_RETLIT_type |=> o_stack_pop)
      else $error("Literal return did not pop.");
   AST_RETLIT_TWO: assert property (
      active && opk.kind == OP_RETLIT_type |=> o_flush ##1 !o_flush)
      else $error("Literal return not two cycles.");
   AST_IDLE: assert property (
      active && opk.kind == OP_IDLE_type |=> pc_ff == $past(pc_ff) + 11'h001
      && $stable(w_ff) && !o_flush)
      else $error("Idle changed state.");

   AST_POP_ONE: assert property (
      o_stack_pop |=> !o_stack_pop)
      else $error("Stack pop held longer than one cycle.");
   AST_FLAGS_KEPT: assert property (
      is_ret |=> $stable(o_status_flags))
      else $error("Return changed the status flags.");
   AST_FLUSH_W: assert property (
      o_flush |=> $stable(w_ff) && !o_flush)
      else $error("Word in flush cycle reached the accumulator.");
   AST_FLUSH_CFG: assert property (
      o_flush && opk.kind == OP_LDCFG_type && !i_file_wr
      |=> $stable(cfg_ff))
      else $error("Word in flush cycle reached the config.");

   COV_IRQRET: cover property (active && opk.kind == OP_IRQRET_type);
   COV_RETLIT: cover property (active && opk.kind == OP_RETLIT_type);
   COV_LDCFG: cover property (active && opk.kind == OP_LDCFG_type);
   COV_IDLE: cover property (active && opk.kind == OP_IDLE_type);
   COV_FLUSH_DROP: cover property (o_flush && opk.kind != OP_IDLE_type);
endmodule : return_and_misc_op_decode

// ---- prog_mem_model.sv ----
// Program memory model giving one instruction word for each counter value.
// Assumes the bench preloads words; places never loaded hold idle words.
`timescale 1ns/1ps
module prog_mem_model (
   // Fetch address
   input  wire logic [10:0] i_addr,
   // Fetched word
   output logic [13:0]      o_word
);
   logic [13:0] mem [0:2047];
   initial begin
      foreach (mem[a]) mem[a] = 14'h0000;
   end
   assign o_word = mem[i_addr];
endmodule : prog_mem_model

// ---- return_and_misc_op_decode_tb.sv ----
// Bench for the return and miscellaneous opcode execute stage.
// Assumes the program memory model and the stack top driven by the bench.
`timescale 1ns/1ps
module return_and_misc_op_decode_tb;
   import retdec_pkg::*;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [13:0] instr_word;
   logic [10:0] i_stack_top_entry = 11'h010;
   logic [6:0]  i_file_addr = 7'h00;
   logic        i_file_wr = 1'b0;
   logic [7:0]  i_file_wdata = 8'h00;
   logic [10:0] pc;
   logic        pop;
   logic        flush;
   logic        gate;
   logic [7:0]  rdata;
   logic [7:0]  w_reg;
   logic [7:0]  cfg;
   logic [7:0]  flags;
   int          err_total = 0;
   int          n_compared = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   prog_mem_model i_prog_mem_model (.i_addr(pc), .o_word(instr_word));
   return_and_misc_op_decode i_return_and_misc_op_decode (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_instr_word(instr_word),
      .o_program_counter(pc), .i_stack_top_entry(i_stack_top_entry),
      .o_stack_pop(pop), .i_file_addr(i_file_addr), .i_file_wr(i_file_wr),
      .i_file_wdata(i_file_wdata), .o_file_rdata(rdata), .o_w_reg(w_reg),
      .o_prescale_cfg(cfg), .o_global_irq_gate(gate),
      .o_status_flags(flags), .o_flush(flush));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task step;
      @(posedge i_ref_clk);
      #1;
   endtask : step
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task t_reset;
      chk(pc, 11'h000);
      chk({w_reg, cfg[7:5]}, {8'h00, 3'h7});
      chk({gate, pop, flush, rdata}, 11'h000);
   endtask : t_reset
   task t_retlit;
      step;
      chk(pc, 11'h001);
      step;
      chk(pc, 11'h010);
      chk(w_reg, 11'h055);
      chk({pop, flush, flags}, {2'h3, 8'h00});
      step;
      chk({pop, flush, cfg}, {2'h0, 8'hFF});
      chk(pc, 11'h011);
   endtask : t_retlit
   task t_ldcfg;
      @(posedge i_ref_clk) i_stack_top_entry <= 11'h030;
      #1;
      chk({flags, cfg}, {8'h00, 8'h55});
      step;
      chk({pc, w_reg, cfg}, {11'h013, 8'h55, 8'h55});
   endtask : t_ldcfg
   task t_irqret;
      int n;
      step;
      chk({pc, gate}, {11'h030, 1'b1});
      chk({pop, flush, flags, w_reg}, {2'h3, 8'h00, 8'h55});
      n = 0;
      while (flush === 1'b1 && n < 4) begin
         step;
         n++;
      end
      chk({pc, n[1:0]}, {11'h031, 2'h1});
   endtask : t_irqret
   task t_file;
      @(posedge i_ref_clk);
      i_file_wr <= 1'b1;
      i_file_addr <= 7'h01;
      i_file_wdata <= 8'hA5;
      @(posedge i_ref_clk) i_file_wr <= 1'b0;
      #1;
      chk(cfg, 11'h0A5);
      step;
      chk(rdata, 11'h0A5);
      @(posedge i_ref_clk) i_file_addr <= 7'h0B;
      step;
      chk(rdata[7], 1'b1);
   endtask : t_file
   task t_midreset;
      @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      i_stack_top_entry <= 11'h040;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1;
      chk({pc, w_reg, cfg, gate, flush}, {11'h000, 8'h00, 8'hFF, 2'h0});
      step;
      chk(pc, 11'h001);
      step;
      chk({pc, w_reg, pop}, {11'h040, 8'h55, 1'b1});
      @(posedge i_ref_clk);
      i_file_wr <= 1'b1;
      i_file_wdata <= 8'h00;
      #1;
      chk({pc, flush}, {11'h041, 1'b0});
      @(posedge i_ref_clk) i_file_wr <= 1'b0;
      #1;
      chk({pc, pop, gate}, {11'h040, 2'h3});
      step;
      chk(rdata, 8'h80);
   endtask : t_midreset
   initial begin
      // Unused counts are cut short so a hung design still reaches a verdict.
      repeat (2000) @(posedge i_ref_clk);
      err_total++;
      conclude;
   end
   initial begin
      #1;
      i_prog_mem_model.mem[1] = 14'h3755;
      i_prog_mem_model.mem[16] = 14'h0062;
      i_prog_mem_model.mem[17] = 14'h0062;
      i_prog_mem_model.mem[18] = 14'h0060;
      i_prog_mem_model.mem[19] = 14'h0009;
      i_prog_mem_model.mem[65] = 14'h0009;
      repeat (8) @(posedge i_ref_clk);
      #1;
      t_reset;
      @(posedge i_ref_clk) i_rst_n <= 1'b1;
      #1;
      t_retlit;
      t_ldcfg;
      t_irqret;
      t_file;
      t_midreset;
      conclude;
   end
endmodule : return_and_misc_op_decode_tb
